// ---- logic/pmi_pkg.sv ----
package pmi_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] REG_SEL_TO_STROBE  = 8'h00;
  localparam logic [7:0] REG_STROBE_WIDTH   = 8'h04;
  localparam logic [7:0] REG_STROBE_TO_DSEL = 8'h08;
  localparam logic [7:0] REG_READ_ACCESS    = 8'h0C;
  localparam logic [7:0] REG_STATUS         = 8'h10;
  localparam logic [7:0] REG_BOOT_WORD      = 8'h14;

  // Status field positions
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_BOOT_BIT  = 1;
  localparam int STAT_ERROR_BIT = 2;

  // Wait-state limits and reset defaults, sized for a 120 ns part
  localparam int           WAIT_W            = 5;
  localparam logic [4:0]   MAX_WAITS         = 5'h13;
  localparam logic [4:0]   DEF_SEL_TO_STROBE = 5'h02;
  localparam logic [4:0]   DEF_STROBE_WIDTH  = 5'h0B;
  localparam logic [4:0]   DEF_STROBE_TO_DSL = 5'h02;
  localparam logic [4:0]   DEF_READ_ACCESS   = 5'h13;

  // Flash windows: 16 MB each, selected by the top address byte
  localparam int           FLASH_AW          = 24;
  localparam int           DATA_W            = 16;
  localparam logic [7:0]   WINDOW_FIRST      = 8'hF8;
  localparam logic [7:0]   WINDOW_BOOT       = 8'hF9;
  localparam logic [7:0]   WINDOW_THIRD      = 8'hFA;
  localparam logic [31:0]  BOOT_ADDR         = 32'hF900_0000;

  // Select index codes
  localparam logic [1:0]   SEL_FIRST         = 2'h0;
  localparam logic [1:0]   SEL_BOOT          = 2'h1;
  localparam logic [1:0]   SEL_THIRD         = 2'h2;
  localparam logic [1:0]   SEL_NONE          = 2'h3;

  // Cycle sequencer states, Gray along write and read paths
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD   = 3'h2,
    ST_ACCESS = 3'h4
  } pmi_state_type;

  // Memory request carried from the user port
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [15:0] wdata;
  } pmi_req_type;

  // Clamp a software value to the supported wait-state range
  function automatic logic [4:0] pmiClampWaits(input logic [31:0] value);
    if (value > 32'(MAX_WAITS)) begin
      return MAX_WAITS;
    end
    return value[4:0];
  endfunction

  // Decode the top address byte to a select index
  function automatic logic [1:0] pmiDecodeSelect(input logic [31:0] addr);
    case (addr[31:24])
      WINDOW_FIRST: return SEL_FIRST;
      WINDOW_BOOT:  return SEL_BOOT;
      WINDOW_THIRD: return SEL_THIRD;
      default:      return SEL_NONE;
    endcase
  endfunction

endpackage

// ---- logic/pmi_wait_counter.sv ----
`timescale 1ns/1ps
module pmi_wait_counter
  import pmi_pkg::*;
(
  input  wire logic              clk,       // System clock
  input  wire logic              rst_n,     // Synchronous reset, active low
  input  wire logic              load,      // Start a new phase
  input  wire logic [WAIT_W-1:0] loadValue, // Phase length in cycles
  output logic                   done       // Last cycle of the phase
);

  logic [WAIT_W-1:0] countReg;

  // A zero count still yields one cycle so a phase never vanishes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      countReg <= '0;
    end else if (load) begin
      countReg <= loadValue;
    end else if (countReg != '0) begin
      countReg <= countReg - WAIT_W'(1);
    end
  end

  assign done = (countReg <= WAIT_W'(1));

endmodule

// ---- logic/pmi_flash_if.sv ----
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
// Function
// RULE1: three active-low selects, 16 MB each
// RULE2: middle select reserved for boot flash
// RULE3: per-parameter waits, capped at nineteen
// RULE4: select-to-strobe lasts programmed waits, default 2
// RULE5: strobe width lasts programmed waits, default 11
// RULE6: strobe-to-deselect hold lasts programmed waits, default 2
// RULE7: read data captured after access waits, default 19
// RULE8: software sizes access from largest access time
// RULE9: boot fetch at 0xF9000000 after reset
// RULE10: reset waits suit a 120 ns flash
// RULE11: select, strobe, release strobe, release select
module pmi_flash_if
  import pmi_pkg::*;
(
  input  wire logic              clk,                // System clock, 20 MHz
  input  wire logic              rst_n,              // Synchronous reset, active low
  input  wire logic              psel,               // APB select
  input  wire logic              penable,            // APB access phase
  input  wire logic              pwrite,             // APB write
  input  wire logic [7:0]        paddr,              // APB byte address
  input  wire logic [31:0]       pwdata,             // APB write data
  output logic [31:0]            prdata,             // APB read data
  output logic                   pready,             // APB ready
  output logic                   pslverr,            // APB error on unmapped address
  input  wire logic              reqValid,           // Memory request valid
  output logic                   reqReady,           // Memory request taken
  input  wire pmi_req_type       req,                // Write flag, address, write data
  output logic                   rspValid,           // One-cycle completion pulse
  output logic                   rspError,           // Address outside every window
  output logic [DATA_W-1:0]      rspData,            // Captured read data
  output logic                   progMemSelectFirstN, // Select of first flash
  output logic                   bootFlashSelectN,   // Select of boot flash
  output logic                   progMemSelectThirdN, // Select of third flash
  output logic                   flashWriteStrobeN,  // Write strobe
  output logic                   flashOutEnableN,    // Flash output enable for reads
  output logic [FLASH_AW-1:0]    flashAddr,          // Flash byte address
  output logic [DATA_W-1:0]      flashDataOut,       // Data driven to flash
  output logic                   flashDataOe,        // High while driving data
  input  wire logic [DATA_W-1:0] flashDataIn         // Data from flash
);

  logic [WAIT_W-1:0] selectToStrobeWaitsReg;
  logic [WAIT_W-1:0] strobeWidthWaitsReg;
  logic [WAIT_W-1:0] strobeToDeselectWaitsReg;
  logic [WAIT_W-1:0] readAccessWaitsReg;
  pmi_state_type     stateReg;
  pmi_state_type     stateNext;
  logic [1:0]        curSelReg;
  logic [1:0]        curSelNext;
  logic [2:0]        selectNReg;
  logic [2:0]        selectNNext;
  logic              bootPendingReg;
  logic              bootDoneReg;
  logic              errorReg;
  logic [DATA_W-1:0] bootWordReg;
  logic              phaseDone;
  logic              phaseLoad;
  logic [WAIT_W-1:0] phaseValue;
  logic              startCycle;
  pmi_req_type       curReq;
  logic [1:0]        reqSel;
  logic              apbWrite;

  assign curReq     = bootPendingReg ? pmi_req_type'{write: 1'b0, addr: BOOT_ADDR, wdata: '0} : req;
  assign reqSel     = pmiDecodeSelect(curReq.addr);
  assign reqReady   = (stateReg == ST_IDLE) && !bootPendingReg;
  assign startCycle = (stateReg == ST_IDLE) && (bootPendingReg || reqValid);
  assign apbWrite   = psel && penable && pwrite;
  assign pready     = 1'b1; // Registers answer without wait states

  // Wait-state registers; oversize writes clamp at the ceiling
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selectToStrobeWaitsReg   <= DEF_SEL_TO_STROBE;  // see RULE4 RULE10
      strobeWidthWaitsReg      <= DEF_STROBE_WIDTH;   // see RULE5 RULE10
      strobeToDeselectWaitsReg <= DEF_STROBE_TO_DSL;  // see RULE6 RULE10
      readAccessWaitsReg       <= DEF_READ_ACCESS;    // see RULE7 RULE10
    end else if (apbWrite) begin
      case (paddr)
        REG_SEL_TO_STROBE:  selectToStrobeWaitsReg   <= pmiClampWaits(pwdata); // see RULE3
        REG_STROBE_WIDTH:   strobeWidthWaitsReg      <= pmiClampWaits(pwdata); // see RULE3
        REG_STROBE_TO_DSEL: strobeToDeselectWaitsReg <= pmiClampWaits(pwdata); // see RULE3
        REG_READ_ACCESS:    readAccessWaitsReg       <= pmiClampWaits(pwdata); // see RULE3 RULE8
        default: ;
      endcase
    end
  end

  // Read data and error are registered in the setup phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        REG_SEL_TO_STROBE:  prdata <= 32'(selectToStrobeWaitsReg);
        REG_STROBE_WIDTH:   prdata <= 32'(strobeWidthWaitsReg);
        REG_STROBE_TO_DSEL: prdata <= 32'(strobeToDeselectWaitsReg);
        REG_READ_ACCESS:    prdata <= 32'(readAccessWaitsReg);
        REG_STATUS: begin
          prdata                 <= '0;
          prdata[STAT_BUSY_BIT]  <= (stateReg != ST_IDLE);
          prdata[STAT_BOOT_BIT]  <= bootDoneReg;
          prdata[STAT_ERROR_BIT] <= errorReg;
        end
        REG_BOOT_WORD:      prdata <= 32'(bootWordReg);
        default: begin
          prdata  <= '0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Next state and phase loads; each phase lasts its programmed count, one cycle when the count is zero
  always_comb begin
    stateNext  = stateReg;
    curSelNext = curSelReg;
    phaseLoad  = 1'b0;
    phaseValue = '0;
    case (stateReg)
      ST_IDLE: begin
        if (startCycle && reqSel != SEL_NONE) begin
          curSelNext = reqSel;
          phaseLoad  = 1'b1;
          if (curReq.write) begin
            stateNext  = ST_SETUP;
            phaseValue = selectToStrobeWaitsReg; // see RULE4
          end else begin
            stateNext  = ST_ACCESS;
            phaseValue = readAccessWaitsReg;     // see RULE7
          end
        end
      end
      ST_SETUP: begin
        if (phaseDone) begin
          stateNext  = ST_STROBE;                // see RULE11
          phaseLoad  = 1'b1;
          phaseValue = strobeWidthWaitsReg;      // see RULE5
        end
      end
      ST_STROBE: begin
        if (phaseDone) begin
          stateNext  = ST_HOLD;                  // see RULE11
          phaseLoad  = 1'b1;
          phaseValue = strobeToDeselectWaitsReg; // see RULE6
        end
      end
      ST_HOLD: begin
        if (phaseDone) begin
          stateNext  = ST_IDLE;
          curSelNext = SEL_NONE;
        end
      end
      ST_ACCESS: begin
        if (phaseDone) begin
          stateNext  = ST_IDLE;
          curSelNext = SEL_NONE;
        end
      end
      default: begin
        stateNext  = ST_IDLE;
        curSelNext = SEL_NONE;
      end
    endcase
  end

  // Only the current select can be low, so two parts never fight
  always_comb begin
    selectNNext = 3'h7;
    if (stateNext != ST_IDLE && curSelNext != SEL_NONE) begin
      selectNNext[curSelNext] = 1'b0; // see RULE1 RULE2 RULE11
    end
  end

  pmi_wait_counter u_phase (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (phaseLoad),
    .loadValue (phaseValue),
    .done      (phaseDone)
  );

  // Sequencer and registered pin drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg          <= ST_IDLE;
      curSelReg         <= SEL_NONE;
      selectNReg        <= 3'h7;
      flashWriteStrobeN <= 1'b1;
      flashOutEnableN   <= 1'b1;
      flashDataOe       <= 1'b0;
    end else begin
      stateReg          <= stateNext;
      curSelReg         <= curSelNext;
      selectNReg        <= selectNNext;
      flashWriteStrobeN <= (stateNext != ST_STROBE); // see RULE11
      flashOutEnableN   <= (stateNext != ST_ACCESS);
      flashDataOe       <= (stateNext == ST_SETUP) || (stateNext == ST_STROBE) || (stateNext == ST_HOLD);
    end
  end

  assign progMemSelectFirstN = selectNReg[SEL_FIRST];
  assign bootFlashSelectN    = selectNReg[SEL_BOOT];  // see RULE2
  assign progMemSelectThirdN = selectNReg[SEL_THIRD];

  // Address and data latch when a cycle starts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashAddr    <= '0;
      flashDataOut <= '0;
    end else if (startCycle) begin
      flashAddr    <= curReq.addr[FLASH_AW-1:0];
      flashDataOut <= curReq.wdata;
    end
  end

  // Completion, read capture at the end of the access phase, boot fetch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rspValid       <= 1'b0;
      rspError       <= 1'b0;
      rspData        <= '0;
      bootPendingReg <= 1'b1; // see RULE9
      bootDoneReg    <= 1'b0;
      bootWordReg    <= '0;
      errorReg       <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      if (startCycle && reqSel == SEL_NONE && !bootPendingReg) begin
        rspValid <= 1'b1;
        rspError <= 1'b1;
        errorReg <= 1'b1;
      end else if (stateReg == ST_ACCESS && phaseDone) begin
        if (bootPendingReg) begin
          bootPendingReg <= 1'b0;
          bootDoneReg    <= 1'b1;
          bootWordReg    <= flashDataIn; // see RULE9
        end else begin
          rspValid <= 1'b1;
          rspError <= 1'b0;
          rspData  <= flashDataIn;       // see RULE7
        end
      end else if (stateReg == ST_HOLD && phaseDone) begin
        rspValid <= 1'b1;
        rspError <= 1'b0;
      end
    end
  end

  // Helper counters watched only by the checks below
  logic [7:0] selLowCnt;
  logic [7:0] strobeLowCnt;
  logic [7:0] holdCnt;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selLowCnt    <= '0;
      strobeLowCnt <= '0;
      holdCnt      <= '0;
    end else begin
      selLowCnt    <= (&selectNReg) ? 8'h00 : selLowCnt + 8'h01;
      strobeLowCnt <= flashWriteStrobeN ? 8'h00 : strobeLowCnt + 8'h01;
      holdCnt      <= (stateReg == ST_HOLD) ? holdCnt + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ONE_SELECT: assert property ($countones(~selectNReg) <= 1) // see RULE1
    else $error("More than one flash select low");
  AST_BOOT_SELECT: assert property ((startCycle && curReq.addr[31:24] != WINDOW_BOOT) |=> bootFlashSelectN) // see RULE2
    else $error("Boot select low outside boot window");
  AST_WAIT_CAP: assert property ((strobeWidthWaitsReg <= MAX_WAITS) && (readAccessWaitsReg <= MAX_WAITS)
    && (selectToStrobeWaitsReg <= MAX_WAITS) && (strobeToDeselectWaitsReg <= MAX_WAITS)) // see RULE3
    else $error("Wait count above ceiling");
  AST_SETUP_LEN: assert property ($fell(flashWriteStrobeN) |->
    selLowCnt == ((selectToStrobeWaitsReg == '0) ? 8'h01 : 8'(selectToStrobeWaitsReg))) // see RULE4
    else $error("Select-to-strobe length wrong");
  AST_STROBE_LEN: assert property ($rose(flashWriteStrobeN) |->
    $past(strobeLowCnt) + 8'h01 == ((strobeWidthWaitsReg == '0) ? 8'h01 : 8'(strobeWidthWaitsReg))) // see RULE5
    else $error("Strobe width wrong");
  AST_HOLD_LEN: assert property ((stateReg == ST_HOLD && phaseDone) |=> (&selectNReg) &&
    $past(holdCnt) + 8'h01 == ((strobeToDeselectWaitsReg == '0) ? 8'h01 : 8'(strobeToDeselectWaitsReg))) // see RULE6
    else $error("Hold length wrong");
  AST_READ_CAPTURE: assert property ((rspValid && !rspError && flashWriteStrobeN && !$past(flashOutEnableN)) |->
    rspData == $past(flashDataIn) && $past(selLowCnt) + 8'h01 >= 8'(readAccessWaitsReg)) // see RULE7
    else $error("Read data captured early or wrong");
  AST_BOOT_FETCH: assert property ($rose(bootDoneReg) |-> !$past(bootFlashSelectN) &&
    $past(flashAddr) == BOOT_ADDR[FLASH_AW-1:0] && bootWordReg == $past(flashDataIn)) // see RULE9
    else $error("Boot fetch not from boot address");
  AST_DEFAULTS: assert property (!$past(rst_n) |-> strobeWidthWaitsReg == DEF_STROBE_WIDTH &&
    readAccessWaitsReg == DEF_READ_ACCESS && selectToStrobeWaitsReg == DEF_SEL_TO_STROBE) // see RULE10
    else $error("Wait defaults wrong after reset");
  AST_STROBE_IN_SELECT: assert property (!flashWriteStrobeN |-> !(&selectNReg) ##1 !(&selectNReg)) // see RULE11
    else $error("Strobe outside select");

endmodule

// ---- verification/pmi_flash_model.sv ----
`timescale 1ns/1ps
// Behavioural NOR part: slow to present data, toggling garbage when not read
module pmi_flash_model #(
  parameter logic [15:0] SEED = 16'h0000, // Fill pattern of the array
  parameter int          ACC  = 3         // Cycles from select to valid data
) (
  input  wire logic        clk,  // System clock
  input  wire logic        csN,  // Select, active low
  input  wire logic        weN,  // Write strobe, active low
  input  wire logic        oeN,  // Output enable, active low
  input  wire logic [23:0] addr, // Byte address
  input  wire logic [15:0] din,  // Write data
  output logic      [15:0] q     // Read data
);
  logic [15:0] mem [0:255];
  logic [15:0] qReg   = 16'h0000;
  logic        filled = 1'b0;
  int          age    = 0;

  // First edge loads a known fill so every word read back is predictable
  always @(posedge clk) begin
    if (!filled) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= SEED ^ 16'(i);
      end
      filled <= 1'b1;
    end else if (csN === 1'b0 && weN === 1'b0) begin
      mem[addr[8:1]] <= din;
    end
  end

  // Idle bus inverts each cycle so a stale sample never looks right by chance
  always @(posedge clk) begin
    age  <= (csN !== 1'b0) ? 0 : age + 1;
    qReg <= (csN === 1'b0 && oeN === 1'b0 && age >= ACC) ? mem[addr[8:1]] : ~qReg;
  end

  assign q = qReg;
endmodule

// ---- verification/nor_program_memory_interface_tb_top.sv ----
`timescale 1ns/1ps
module nor_program_memory_interface_tb_top;
  import pmi_pkg::*;

  // Distinct fills tell the three parts apart
  localparam logic [15:0] SEED_FIRST = 16'h1100;
  localparam logic [15:0] SEED_BOOT  = 16'h5A00;
  localparam logic [15:0] SEED_THIRD = 16'hC300;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        reqValid, reqReady, rspValid, rspError, flashDataOe;
  logic        progMemSelectFirstN, bootFlashSelectN, progMemSelectThirdN;
  logic        flashWriteStrobeN, flashOutEnableN;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rspData, flashDataOut, flashDataIn, q0, q1, q2;
  logic [23:0] flashAddr;
  logic [2:0]  lowSeen, sel;
  pmi_req_type req;
  int          mismatches, comparisons, ts, tw, th, ta, td;
  logic [7:0]  regAddr [4] = '{REG_SEL_TO_STROBE, REG_STROBE_WIDTH, REG_STROBE_TO_DSEL, REG_READ_ACCESS};
  logic [31:0] defWaits [4] = '{32'h2, 32'hB, 32'h2, 32'h13};

  pmi_flash_if pmi_flash_if_inst (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reqValid, .reqReady, .req, .rspValid, .rspError, .rspData,
    .progMemSelectFirstN, .bootFlashSelectN, .progMemSelectThirdN, .flashWriteStrobeN,
    .flashOutEnableN, .flashAddr, .flashDataOut, .flashDataOe, .flashDataIn
  );

  // One part per select; the read bus follows whichever select is low
  pmi_flash_model #(.SEED(SEED_FIRST)) pmi_flash_model_inst_first (.clk, .csN(progMemSelectFirstN),
    .weN(flashWriteStrobeN), .oeN(flashOutEnableN), .addr(flashAddr), .din(flashDataOut), .q(q0));
  pmi_flash_model #(.SEED(SEED_BOOT)) pmi_flash_model_inst_boot (.clk, .csN(bootFlashSelectN),
    .weN(flashWriteStrobeN), .oeN(flashOutEnableN), .addr(flashAddr), .din(flashDataOut), .q(q1));
  pmi_flash_model #(.SEED(SEED_THIRD)) pmi_flash_model_inst_third (.clk, .csN(progMemSelectThirdN),
    .weN(flashWriteStrobeN), .oeN(flashOutEnableN), .addr(flashAddr), .din(flashDataOut), .q(q2));
  assign flashDataIn = !progMemSelectFirstN ? q0 : (!bootFlashSelectN ? q1 : q2);

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded waits end the run instead of hanging
  task automatic expire(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      end_sim();
    end
  endtask

  // APB transfer: setup, access until pready, release; result in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    expire(n, 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Memory request; counts the pin phases cycle by cycle until completion
  task automatic mem(input logic w, input logic [31:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{write: w, addr: a, wdata: d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 200);
    expire(n, 200);
    reqValid <= 1'b0;
    {ts, tw, th, ta, td, n} = '0;
    lowSeen = 3'h0;
    // First sample is the cycle right after the take edge, where the select falls
    do begin
      #1;
      n++;
      sel = ~{progMemSelectFirstN, bootFlashSelectN, progMemSelectThirdN};
      lowSeen |= sel;
      if ($countones(sel) > 1) chk(32'(sel), 32'h0);
      if (sel != 3'h0 && flashWriteStrobeN === 1'b1) begin
        if (tw == 0) ts++;
        else th++;
      end
      if (flashWriteStrobeN === 1'b0) tw++;
      if (flashOutEnableN === 1'b0) ta++;
      if (flashDataOe === 1'b1) td++;
      if (rspValid !== 1'b1) @(posedge clk);
    end while (rspValid !== 1'b1 && n < 100);
    expire(n, 100);
  endtask

  task automatic wcyc(input logic [31:0] a, input logic [15:0] d, input int s, w, h, input logic [2:0] exp);
    mem(1'b1, a, d);
    chk(ts, s);
    chk(tw, w);
    chk(th, h);
    chk(ta, 0);
    chk(td, s + w + h);
    chk(32'(lowSeen), 32'(exp));
  endtask

  task automatic rcyc(input logic [31:0] a, input logic [15:0] d, input int acc, input logic [2:0] exp);
    mem(1'b0, a, 16'h0000);
    chk(ta, acc);
    chk(tw, 0);
    chk(td, 0);
    chk(32'(rspData), 32'(d));
    chk(32'(lowSeen), 32'(exp));
  endtask

  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, reqValid} = '0;
    {paddr, pwdata, mismatches, comparisons} = '0;
    req = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, regAddr[i], 32'h0);
      chk(rd, defWaits[i]);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1);
    $display("Test defaults done");
    wcyc(32'hF800_0010, 16'h1234, 2, 11, 2, 3'h4);
    apb(1'b0, REG_BOOT_WORD, 32'h0);
    chk(rd, 32'(SEED_BOOT));
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    $display("Test boot and default write done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, regAddr[i], 32'h1F);
      apb(1'b0, regAddr[i], 32'h0);
      chk(rd, 32'h13);
    end
    wcyc(32'hF800_0020, 16'h0F0F, 19, 19, 19, 3'h4);
    $display("Test wait clamp done");
    // Read access sized from the slowest access time of the part, plus margin
    for (int i = 0; i < 4; i++) apb(1'b1, regAddr[i], i == 3 ? 32'h6 : (i == 1 ? 32'h1 : 32'h3 + i));
    wcyc(32'hFA00_0020, 16'hBEEF, 3, 1, 5, 3'h1);
    rcyc(32'hFA00_0020, 16'hBEEF, 6, 3'h1);
    rcyc(32'hF800_0010, 16'h1234, 6, 3'h4);
    rcyc(32'hF900_0002, SEED_BOOT ^ 16'h0001, 6, 3'h2);
    $display("Test programmed waits done");
    mem(1'b0, 32'h1200_0000, 16'h0000);
    chk(32'(rspError), 32'h1);
    chk(32'(lowSeen), 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    $display("Test unmapped request done");
    end_sim();
  end
endmodule
